// [rtl/ltar_supervisor.sv]
// peripheral-side link supervisor: timeouts, error record, turnaround answers
module ltar_supervisor #(
  parameter int TIMER_W = 16
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic [7:0]                  paddr,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [31:0]                 pwdata,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [1:0]                  lane_lp_pin,
  input  wire logic                        link_clk_pin,
  input  wire logic [ltar_pkg::ERR_W-1:0]  err_pulse,
  input  wire logic                        seq_valid,
  input  wire logic                        turnaround_rx,
  input  wire logic                        read_req,
  input  wire logic                        reset_entry,
  input  wire logic                        tx_done,
  output logic                             resp_valid,
  output logic [1:0]                       resp_kind,
  output logic [ltar_pkg::ERR_W-1:0]       resp_err_flags,
  output logic                             turnaround_tx,
  output logic                             lane_release,
  output logic                             periph_reset,
  output logic                             end_pkt_en
);
  // ==========================================================
  // elaboration check
  if (TIMER_W < 12 || TIMER_W > 32) begin : g_bad_w
    $error("ltar_supervisor: TIMER_W must hold the default limits");
  end

  ltar_pkg::ltar_state_type state;
  ltar_pkg::ltar_resp_type  kind;
  logic [1:0]                  ctrl;
  logic [TIMER_W-1:0]          ltx_lim;
  logic [TIMER_W-1:0]          ta_lim;
  logic [TIMER_W-1:0]          rst_lim;
  logic [ltar_pkg::ERR_W-1:0]  rec;
  logic [ltar_pkg::ERR_W-1:0]  set_vec;
  logic [15:0]                 hs_cnt;
  logic [1:0]                  lane_s1;
  logic [1:0]                  lane;
  logic                        lclk_s1;
  logic                        lclk_s2;
  logic                        lclk_q;
  logic                        hs_seen;
  logic                        lp_req_seen;
  logic                        fc_det;
  logic                        pend_read;
  logic                        pend_err;
  logic                        pend_ack;
  logic                        ta_low;
  logic                        ltx_exp;
  logic                        ta_exp;
  logic                        rst_exp;
  logic                        take_turn;
  logic                        last_done;
  logic                        rec_clear;
  logic                        wr;
  logic                        rd_hit;
  logic [31:0]                 rd_mux;
  logic                        at_stop;

  // ==========================================================
  // pin synchronisers; first stage read by second only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lane_s1 <= ltar_pkg::LANE_STOP;
      lane    <= ltar_pkg::LANE_STOP;
      lclk_s1 <= 1'b0;
      lclk_s2 <= 1'b0;
      lclk_q  <= 1'b0;
    end else begin
      lane_s1 <= lane_lp_pin;
      lane    <= lane_s1;
      lclk_s1 <= link_clk_pin;
      lclk_s2 <= lclk_s1;
      lclk_q  <= lclk_s2;
    end
  end
  assign at_stop = (lane == ltar_pkg::LANE_STOP);

  // ==========================================================
  // APB slave, zero wait states
  assign wr      = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !rd_hit;
  assign end_pkt_en = ctrl[ltar_pkg::CTRL_END_PKT_BIT];

  always_comb begin
    rd_hit = 1'b1;
    unique case (paddr)
      ltar_pkg::REG_CTRL:   rd_mux = {30'h0, ctrl};
      ltar_pkg::REG_LTX:    rd_mux = 32'(ltx_lim);
      ltar_pkg::REG_TA:     rd_mux = 32'(ta_lim);
      ltar_pkg::REG_RST:    rd_mux = 32'(rst_lim);
      ltar_pkg::REG_STATUS: rd_mux = {13'h0, 3'(state), rec};
      ltar_pkg::REG_HSCNT:  rd_mux = {16'h0, hs_cnt};
      default: begin
        rd_mux = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end

  // read data captured in the setup cycle, stable through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl    <= ltar_pkg::CTRL_RESET;
      ltx_lim <= TIMER_W'(ltar_pkg::LTX_CYCLES);
      ta_lim  <= TIMER_W'(ltar_pkg::TA_CYCLES);
      rst_lim <= TIMER_W'(ltar_pkg::RST_CYCLES);
    end else if (wr) begin
      unique case (paddr)
        ltar_pkg::REG_CTRL: ctrl    <= pwdata[1:0];
        ltar_pkg::REG_LTX:  ltx_lim <= pwdata[TIMER_W-1:0];
        ltar_pkg::REG_TA:   ta_lim  <= pwdata[TIMER_W-1:0];
        ltar_pkg::REG_RST:  rst_lim <= pwdata[TIMER_W-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // timers
  // reset entry wins over a turnaround in the same cycle
  assign take_turn = (state == ltar_pkg::ST_RX) && turnaround_rx && !reset_entry;

  ltar_timer #(.W(TIMER_W)) u_ltx (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (take_turn),
    .run     (state == ltar_pkg::ST_TX),
    .limit   (ltx_lim),
    .expire  (ltx_exp)
  );

  ltar_timer #(.W(TIMER_W)) u_ta (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (turnaround_tx),
    .run     (state == ltar_pkg::ST_TA),
    .limit   (ta_lim),
    .expire  (ta_exp)
  );

  ltar_timer #(.W(TIMER_W)) u_rst (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (state == ltar_pkg::ST_RX && reset_entry),
    .run     (state == ltar_pkg::ST_RST),
    .limit   (rst_lim),
    .expire  (rst_exp)
  );

  // ==========================================================
  // false control: low-power request ending in stop without a sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lp_req_seen <= 1'b0;
      fc_det      <= 1'b0;
    end else begin
      fc_det <= 1'b0;
      if (state != ltar_pkg::ST_RX || seq_valid || turnaround_rx) begin
        lp_req_seen <= 1'b0;
      end else if (lane == ltar_pkg::LANE_LP_REQ) begin
        lp_req_seen <= 1'b1;
      end else if (at_stop && lp_req_seen) begin
        lp_req_seen <= 1'b0;
        fc_det      <= 1'b1;
      end
    end
  end

  // ==========================================================
  // error record; a detection in the clearing cycle survives
  always_comb begin
    set_vec = err_pulse;
    set_vec[ltar_pkg::ERR_FALSE_CTRL] = err_pulse[ltar_pkg::ERR_FALSE_CTRL] | fc_det;
    set_vec[ltar_pkg::ERR_PERIPH_TO]  = err_pulse[ltar_pkg::ERR_PERIPH_TO] | ltx_exp;
  end
  assign rec_clear = resp_valid && tx_done && kind == ltar_pkg::RESP_ERR;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec <= '0;
    end else if (ctrl[ltar_pkg::CTRL_BIDIR_BIT]) begin
      rec <= (rec_clear ? '0 : rec) | set_vec;
    end else begin
      rec <= '0;
    end
  end

  // ==========================================================
  // answer to a turnaround, one item per tx_done
  assign resp_valid = (state == ltar_pkg::ST_TX) && (pend_read || pend_err || pend_ack);
  assign resp_kind  = kind;
  assign last_done  = resp_valid && tx_done && !(kind == ltar_pkg::RESP_READ && pend_err);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_read      <= 1'b0;
      pend_err       <= 1'b0;
      pend_ack       <= 1'b0;
      kind           <= ltar_pkg::RESP_ACK;
      resp_err_flags <= '0;
    end else if (take_turn) begin
      // uncorrectable read: report only; corrected: data then report
      pend_read      <= read_req && !rec[ltar_pkg::ERR_ECC_MULTI];
      pend_err       <= |rec;
      pend_ack       <= !read_req && rec == '0;
      resp_err_flags <= rec;
      if (read_req && !rec[ltar_pkg::ERR_ECC_MULTI]) begin
        kind <= ltar_pkg::RESP_READ;
      end else if (|rec) begin
        kind <= ltar_pkg::RESP_ERR;
      end else begin
        kind <= ltar_pkg::RESP_ACK;
      end
    end else if (ltx_exp || last_done) begin
      pend_read <= 1'b0;
      pend_err  <= 1'b0;
      pend_ack  <= 1'b0;
    end else if (resp_valid && tx_done) begin
      pend_read <= 1'b0;
      kind      <= ltar_pkg::RESP_ERR;
    end
  end

  // ==========================================================
  // link state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state         <= ltar_pkg::ST_RX;
      turnaround_tx <= 1'b0;
      lane_release  <= 1'b0;
      ta_low        <= 1'b0;
    end else begin
      turnaround_tx <= 1'b0;
      lane_release  <= 1'b0;
      unique case (state)
        ltar_pkg::ST_RX: begin
          if (reset_entry) begin
            state <= ltar_pkg::ST_RST;
          end else if (turnaround_rx) begin
            state <= ltar_pkg::ST_TX;
          end
        end
        ltar_pkg::ST_TX: begin
          if (ltx_exp) begin
            lane_release <= 1'b1;
            state        <= ltar_pkg::ST_WAIT_STOP;
          end else if (last_done) begin
            turnaround_tx <= 1'b1;
            ta_low <= 1'b0;
            state  <= ltar_pkg::ST_TA;
          end
        end
        ltar_pkg::ST_TA: begin
          // host must leave stop, then drive it back, to acknowledge
          if (!at_stop) begin
            ta_low <= 1'b1;
          end
          if (ta_exp || (ta_low && at_stop)) begin
            state <= ltar_pkg::ST_RX;
          end
        end
        ltar_pkg::ST_WAIT_STOP: begin
          if (at_stop) begin
            state <= ltar_pkg::ST_RX;
          end
        end
        ltar_pkg::ST_RST: begin
          if (rst_exp) begin
            state <= ltar_pkg::ST_RX;
          end
        end
      endcase
    end
  end
  assign periph_reset = (state == ltar_pkg::ST_RST);

  // ==========================================================
  // high-speed transmissions: link clock seen, closed by stop_state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_seen <= 1'b0;
      hs_cnt  <= 16'h0;
    end else if (at_stop) begin
      if (hs_seen) begin
        hs_cnt <= 16'(hs_cnt + 1'b1);
      end
      hs_seen <= 1'b0;
    end else if (lclk_s2 && !lclk_q) begin
      // clock lane only, so the count holds for any data lane count
      hs_seen <= 1'b1;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_clean_turn;
    state == ltar_pkg::ST_RX && !reset_entry && turnaround_rx && rec == '0;
  endsequence

  AST_LTX_RELEASE: assert property (ltx_exp && state == ltar_pkg::ST_TX |=> lane_release && state == ltar_pkg::ST_WAIT_STOP)
    else $error("possession timeout did not release the lanes");
  AST_WAIT_IGNORE: assert property (state == ltar_pkg::ST_WAIT_STOP && !at_stop |=> state == ltar_pkg::ST_WAIT_STOP)
    else $error("left wait before stop state");
  AST_TA_RETURN: assert property (state == ltar_pkg::ST_TA && ta_exp |=> state == ltar_pkg::ST_RX)
    else $error("turnaround timeout did not return to receive");
  AST_RST_END: assert property (state == ltar_pkg::ST_RST && rst_exp |=> !periph_reset && state == ltar_pkg::ST_RX)
    else $error("reset sequence did not end in receive");
  AST_ACCUM: assert property (ctrl[ltar_pkg::CTRL_BIDIR_BIT] && |set_vec |=> (rec & $past(set_vec)) == $past(set_vec))
    else $error("detected error not recorded");
  AST_CLEAR: assert property (rec_clear && set_vec == '0 && ctrl[ltar_pkg::CTRL_BIDIR_BIT] |=> rec == '0)
    else $error("record not cleared after report");
  AST_ACK: assert property (s_clean_turn and !read_req |=> resp_valid && kind == ltar_pkg::RESP_ACK && !pend_err)
    else $error("clean turnaround not answered by acknowledge");
  AST_READ_ONLY: assert property (s_clean_turn and read_req |=> kind == ltar_pkg::RESP_READ && !pend_err && !pend_ack)
    else $error("clean read answered with more than data");
  AST_CORR: assert property (state == ltar_pkg::ST_RX && !reset_entry && turnaround_rx && read_req
                             && rec[ltar_pkg::ERR_ECC_SINGLE] && !rec[ltar_pkg::ERR_ECC_MULTI]
                             |=> kind == ltar_pkg::RESP_READ && pend_err)
    else $error("corrected read not followed by report");
  AST_FC: assert property (fc_det && ctrl[ltar_pkg::CTRL_BIDIR_BIT] |=> rec[ltar_pkg::ERR_FALSE_CTRL])
    else $error("false control not recorded");
endmodule

// [rtl/ltar_pkg.sv]
// package: constants, register map and types of the link supervisor
// How it works
// - possession timeout releases lanes, waits for stop_state
// - turnaround issuer watches lanes, recovers on timeout
// - turnaround timeout exceeds far side's turnaround delay
// - unacknowledged peripheral turnaround returns to receive
// - reset-entry starts reset, then await bus activity
// - errors accumulate across transmissions until turnaround
// - uncorrectable: report only; corrected: data then report
// - record clears once errors are reported
// - packet formats independent of lane count
// - transmission framed by start and end sequences
// - high-speed gap splits packets into transmissions
// - unfinished low-power request flags false control
package ltar_pkg;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int LTX_TIME_NS   = 200000;
  localparam int TA_TIME_NS    = 100000;
  localparam int RST_TIME_NS   = 300000;
  localparam int LTX_CYCLES    = (LTX_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TA_CYCLES     = (TA_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CYCLES    = (RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ==========================================================
  // register map
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_LTX    = 8'h04;
  localparam logic [7:0] REG_TA     = 8'h08;
  localparam logic [7:0] REG_RST    = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_HSCNT  = 8'h14;
  localparam int         CTRL_END_PKT_BIT = 0;
  localparam int         CTRL_BIDIR_BIT = 1;
  localparam logic [1:0] CTRL_RESET     = 2'h2;
  // ==========================================================
  // error record layout
  localparam int ERR_W          = 16;
  localparam int ERR_FALSE_CTRL = 3;
  localparam int ERR_PERIPH_TO  = 4;
  localparam int ERR_ECC_SINGLE = 8;
  localparam int ERR_ECC_MULTI  = 9;
  // ==========================================================
  // lane states and enumerations
  localparam logic [1:0] LANE_STOP   = 2'h3;
  localparam logic [1:0] LANE_LP_REQ = 2'h2;
  typedef enum logic [2:0] {ST_RX, ST_TX, ST_TA, ST_WAIT_STOP, ST_RST} ltar_state_type;
  typedef enum logic [1:0] {RESP_ACK, RESP_READ, RESP_ERR} ltar_resp_type;
endpackage

// [rtl/ltar_timer.sv]
// timeout counter with restart and a single-cycle expiry pulse
module ltar_timer #(
  parameter int W = 16
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         start,
  input  wire logic         run,
  input  wire logic [W-1:0] limit,
  output logic              expire
);
  // ==========================================================
  // elaboration check
  if (W < 2 || W > 32) begin : g_bad_w
    $error("ltar_timer: W out of range");
  end

  logic [W-1:0] cnt;

  // ==========================================================
  // counter; saturates at limit so the pulse fires once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt    <= '0;
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (start) begin
        cnt <= '0;
      end else if (run && cnt != limit) begin
        cnt    <= W'(cnt + 1'b1);
        expire <= (W'(cnt + 1'b1) == limit);
      end
    end
  end
endmodule

// [dv/ltar_host_model.sv]
// far-side host model: takes answer items, acknowledges turnarounds, sends frames
module ltar_host_model #(
  parameter int HOST_WAIT = 40
) (
  input  wire logic  pclk,
  input  wire logic  presetn,
  input  wire logic  resp_valid,
  input  wire logic  turnaround_tx,
  input  wire logic  lane_release,
  input  wire logic  slow,
  input  wire logic  hog,
  input  wire logic  ack_ta,
  output logic       tx_done,
  output logic [1:0] lane_lp_pin,
  output logic       link_clk_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] tk_lanes = 2'h3;
  logic       tk_on    = 1'h0;
  logic       released;
  logic       busy;
  int         wcnt;
  int         dcnt;
  int         acnt;
  initial link_clk_pin = 1'h0;
  // ==========================================================
  // lane levels
  // host wait outlasts the possession limit before stop_state returns
  // lane_release bridges the cycle before released is set: no false stop_state
  assign busy        = hog && (resp_valid || released || lane_release);
  assign lane_lp_pin = tk_on ? tk_lanes : (acnt > 0) ? 2'h2 :
                       (busy && wcnt < HOST_WAIT) ? 2'h1 : 2'h3;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_done  <= 1'h0;
      dcnt     <= 0;
      acnt     <= 0;
      wcnt     <= 0;
      released <= 1'h0;
    end else begin
      if (tx_done) begin
        tx_done <= 1'h0;
        dcnt    <= 0;
      end else if (resp_valid && !hog) begin
        tx_done <= (dcnt >= (slow ? 5 : 0));
        dcnt    <= dcnt + 1;
      end
      acnt <= (turnaround_tx && ack_ta) ? 3 : (acnt > 0) ? acnt - 1 : 0;
      if (busy) wcnt <= wcnt + 1;
      else wcnt <= 0;
      if (lane_release) released <= 1'h1;
      else if (wcnt == HOST_WAIT) released <= 1'h0;
    end
  end
  // ==========================================================
  // frames
  // link clock runs only inside a frame; return to stop_state ends the frame
  task automatic hs_burst(input int n);
    @(posedge pclk);
    tk_lanes <= 2'h0;
    tk_on    <= 1'h1;
    #137;
    repeat (n) begin
      link_clk_pin = 1'h1;
      #400;
      link_clk_pin = 1'h0;
      #400;
    end
    @(posedge pclk);
    tk_on <= 1'h0;
    repeat (6) @(posedge pclk);
  endtask
  task automatic lp_request(input int n);
    @(posedge pclk);
    tk_lanes <= 2'h2;
    tk_on    <= 1'h1;
    repeat (n) @(posedge pclk);
    tk_on <= 1'h0;
    repeat (6) @(posedge pclk);
  endtask
endmodule

// [dv/ltar_supervisor_bench.sv]
// self-checking bench of the link supervisor facing a host model
module ltar_supervisor_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]                  paddr;
  logic [31:0]                 pwdata, prdata, r;
  logic [1:0]                  lane_lp_pin, resp_kind;
  logic                        link_clk_pin, seq_valid, turnaround_rx, read_req, reset_entry, tx_done;
  logic                        resp_valid, turnaround_tx, lane_release, periph_reset, end_pkt_en, slow, hog, ack_ta, e;
  logic [ltar_pkg::ERR_W-1:0]  err_pulse, resp_err_flags;
  logic [ltar_pkg::ERR_W+1:0]  items[$];
  int                          err_count, total_checks, cyc, n;
  initial begin
    pclk = 1'h0;
    forever #50 pclk = ~pclk;
  end
  ltar_supervisor dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lane_lp_pin(lane_lp_pin), .link_clk_pin(link_clk_pin), .err_pulse(err_pulse), .seq_valid(seq_valid),
    .turnaround_rx(turnaround_rx), .read_req(read_req), .reset_entry(reset_entry), .tx_done(tx_done),
    .resp_valid(resp_valid), .resp_kind(resp_kind), .resp_err_flags(resp_err_flags),
    .turnaround_tx(turnaround_tx), .lane_release(lane_release), .periph_reset(periph_reset),
    .end_pkt_en(end_pkt_en));
  ltar_host_model host_u (.pclk(pclk), .presetn(presetn), .resp_valid(resp_valid), .turnaround_tx(turnaround_tx),
    .lane_release(lane_release), .slow(slow), .hog(hog), .ack_ta(ack_ta), .tx_done(tx_done),
    .lane_lp_pin(lane_lp_pin), .link_clk_pin(link_clk_pin));
  // ==========================================================
  // reporting
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic done(input string s);
    $display("test %0s ended, mismatches so far %0d", s, err_count);
  endtask
  // a hang ends the run as a failure
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      err_count++;
      print_verdict();
    end
  end
  always @(posedge pclk) if (resp_valid === 1'h1 && tx_done === 1'h1) items.push_back({resp_kind, resp_err_flags});
  // ==========================================================
  // bus and stimulus tasks
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    // pready is tied high, so this wait ends at the first access edge
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    check(r, exp);
  endtask
  task automatic wait_rx();
    int k;
    k = 0;
    do begin
      apb(1'h0, ltar_pkg::REG_STATUS, 32'h0);
      k++;
    end while (r[18:16] !== 3'h0 && k < 60);
    check(r[18:16], 3'h0);
  endtask
  task automatic err_hit(input logic [ltar_pkg::ERR_W-1:0] m);
    @(posedge pclk);
    err_pulse <= m;
    @(posedge pclk);
    err_pulse <= '0;
  endtask
  task automatic hand_over(input logic rq);
    @(posedge pclk);
    turnaround_rx <= 1'h1;
    read_req      <= rq;
    @(posedge pclk);
    turnaround_rx <= 1'h0;
  endtask
  // items answered between hand-over and the turnaround sent back
  task automatic answer(input logic rq, input int cnt, input logic [1:0] k0, input logic [1:0] k1,
                        input logic [ltar_pkg::ERR_W-1:0] fl);
    int k;
    items.delete();
    hand_over(rq);
    k = 0;
    while (turnaround_tx !== 1'h1 && k < 200) begin
      @(posedge pclk);
      k++;
    end
    check(items.size(), cnt);
    check(items[0][ltar_pkg::ERR_W+1:ltar_pkg::ERR_W], k0);
    check(items[items.size()-1], {k1, fl});
  endtask
  // ==========================================================
  // tests
  initial begin
    {presetn, psel, penable, pwrite, seq_valid, turnaround_rx, read_req, reset_entry, slow, hog} = '0;
    {paddr, pwdata, err_pulse} = '0;
    ack_ta = 1'h1;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    rd_chk(ltar_pkg::REG_CTRL, 32'h2);
    rd_chk(ltar_pkg::REG_LTX, 32'h7D0);
    rd_chk(ltar_pkg::REG_TA, 32'h3E8);
    rd_chk(ltar_pkg::REG_RST, 32'hBB8);
    rd_chk(ltar_pkg::REG_HSCNT, 32'h0);
    check({e, end_pkt_en}, 2'h0);
    rd_chk(8'h18, 32'h0);
    check(e, 1'h1);
    apb(1'h1, ltar_pkg::REG_CTRL, 32'h3);
    // the write lands at this edge: look one edge later
    @(posedge pclk);
    check(end_pkt_en, 1'h1);
    // possession limit must outlast the slow two-item answer
    apb(1'h1, ltar_pkg::REG_LTX, 32'h14);
    apb(1'h1, ltar_pkg::REG_TA, 32'hA);
    apb(1'h1, ltar_pkg::REG_RST, 32'h6);
    rd_chk(ltar_pkg::REG_TA, 32'hA);
    done("registers");
    fork
      host_u.lp_request(6);
      begin
        // sequence confirmed as the lanes leave the request state
        repeat (8) @(posedge pclk);
        seq_valid <= 1'h1;
        @(posedge pclk);
        seq_valid <= 1'h0;
      end
    join
    rd_chk(ltar_pkg::REG_STATUS, 32'h0);
    host_u.lp_request(6);
    rd_chk(ltar_pkg::REG_STATUS, 32'h8);
    err_hit(16'h0200);
    rd_chk(ltar_pkg::REG_STATUS, 32'h208);
    answer(1'h0, 1, ltar_pkg::RESP_ERR, ltar_pkg::RESP_ERR, 16'h0208);
    wait_rx();
    rd_chk(ltar_pkg::REG_STATUS, 32'h0);
    done("error report");
    answer(1'h0, 1, ltar_pkg::RESP_ACK, ltar_pkg::RESP_ACK, 16'h0);
    wait_rx();
    answer(1'h1, 1, ltar_pkg::RESP_READ, ltar_pkg::RESP_READ, 16'h0);
    wait_rx();
    err_hit(16'h0200);
    answer(1'h1, 1, ltar_pkg::RESP_ERR, ltar_pkg::RESP_ERR, 16'h0200);
    wait_rx();
    slow <= 1'h1;
    err_hit(16'h0100);
    answer(1'h1, 2, ltar_pkg::RESP_READ, ltar_pkg::RESP_ERR, 16'h0100);
    wait_rx();
    rd_chk(ltar_pkg::REG_STATUS, 32'h0);
    slow <= 1'h0;
    done("answers");
    ack_ta <= 1'h0;
    answer(1'h0, 1, ltar_pkg::RESP_ACK, ltar_pkg::RESP_ACK, 16'h0);
    apb(1'h0, ltar_pkg::REG_STATUS, 32'h0);
    check(r[18:16], 3'h2);
    wait_rx();
    rd_chk(ltar_pkg::REG_STATUS, 32'h0);
    ack_ta <= 1'h1;
    done("turnaround timeout");
    hog <= 1'h1;
    hand_over(1'h0);
    n = 0;
    while (lane_release !== 1'h1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    check(lane_release, 1'h1);
    @(posedge pclk);
    check(lane_release, 1'h0);
    hand_over(1'h0);
    repeat (3) @(posedge pclk);
    check(resp_valid, 1'h0);
    apb(1'h0, ltar_pkg::REG_STATUS, 32'h0);
    check(r[18:16], 3'h3);
    wait_rx();
    rd_chk(ltar_pkg::REG_STATUS, 32'h10);
    hog <= 1'h0;
    answer(1'h0, 1, ltar_pkg::RESP_ERR, ltar_pkg::RESP_ERR, 16'h0010);
    wait_rx();
    done("possession timeout");
    @(posedge pclk);
    reset_entry <= 1'h1;
    @(posedge pclk);
    reset_entry <= 1'h0;
    n = 0;
    while (periph_reset !== 1'h1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    n = 0;
    while (periph_reset === 1'h1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    check(n, 7);
    wait_rx();
    done("reset entry");
    host_u.hs_burst(6);
    host_u.hs_burst(3);
    rd_chk(ltar_pkg::REG_HSCNT, 32'h2);
    apb(1'h1, ltar_pkg::REG_CTRL, 32'h1);
    err_hit(16'h0008);
    rd_chk(ltar_pkg::REG_STATUS, 32'h0);
    check(end_pkt_en, 1'h1);
    done("frames and one-way link");
    print_verdict();
  end
endmodule
